/* File: include/emu_pin_pkg.sv */
// Constants for the emulation-mode pin control block.
// Assumes one 250 MHz system clock and an asynchronous active-high reset.
package emu_pin_pkg;
  // ==========================================================
  // Mode encodings on the two select pins {high, low}
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ADAPTER = 2'h1;
  localparam logic [1:0] MODE_PROBE = 2'h2;
  localparam logic [1:0] MODE_TEST = 2'h3;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_STRETCH_NS = 64;
  localparam int RESET_STRETCH_CYC = (RESET_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_W = 5;
  localparam logic [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_W'(RESET_STRETCH_CYC);
  // ==========================================================
  // Reset values
  localparam logic [1:0] MODE_RESET = MODE_NORMAL;
  localparam logic SER_DIV2_RESET = 1'b0;
  // Widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int A18_BIT = 18;
endpackage

/* File: logic/emulation_mode_pin_control.sv */
// Pin-direction and pin-state control for the embedded CPU pins.
// Assumes the CPU core supplies drive values on sys_clk_i; mode pins and
// the external reset pin are asynchronous and are synchronised here.
// Functional notes
// [RQ1] Two select pins pick normal, adapter, probe or reserved test mode.
// [RQ2] Adapter mode keeps serial, host UART, chip select and port pins alive.
// [RQ3] Adapter mode turns CPU bus pins to inputs; wait and interrupt-0 drive.
// [RQ4] Probe mode floats every output pin.
// [RQ5] The reserved test encoding must not be selected in operation.
// [RQ6] Reset initialises configuration, boundaries, serial core, ports, host UART.
// [RQ7] Normal mode stretches the reset pin by a one-shot; adapter mode bypasses it.
// [RQ8] Crystal oscillator is disabled in adapter and probe modes.
// [RQ9] Emulator drives memory request and address bit 18 on shared pins.
// [RQ10] Sleep or halt drives memory read and write high when muxed out.
// [RQ11] ROM and RAM selects are held high in sleep or halt.
// [RQ12] Read and write strobes float in sleep or halt; io select when muxed.
// [RQ13] Address outputs float in power-down, bit 18 only when it is address.
// [RQ14] Data bus floats in every power-down mode.
// [RQ15] Host UART emulator is disabled during power-down.
// [RQ16] Serial core clock is undivided after reset.
// [RQ17] Software enables divide-by-two above the rated serial core clock.
module emulation_mode_pin_control
  import emu_pin_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic emu_select_low_i,
  input wire logic emu_select_high_i,
  input wire logic reset_pin_n_i,
  input wire logic cpu_power_down_i,
  input wire logic mrd_mux_sel_i,
  input wire logic mwr_mux_sel_i,
  input wire logic io_mux_sel_i,
  input wire logic a18_is_addr_i,
  input wire logic ser_div2_req_i,
  input wire logic ser_div2_we_i,
  input wire logic cpu_bus_drive_i,
  input wire logic memory_read_strobe_n_i,
  input wire logic memory_write_strobe_n_i,
  input wire logic rom_select_n_i,
  input wire logic ram_select_n_i,
  input wire logic io_select_n_i,
  input wire logic wait_drive_i,
  input wire logic int0_low_i,
  output logic [1:0] mode_o,
  output logic internal_reset_o,
  output logic osc_enable_o,
  output logic host_uart_enable_o,
  output logic peripherals_enable_o,
  output logic ser_div2_o,
  output logic cpu_bus_oe_o,
  output logic addr_oe_o,
  output logic a18_oe_o,
  output logic data_oe_o,
  output logic rw_strobe_oe_o,
  output logic emu_only_oe_o,
  output logic memory_read_strobe_n_o,
  output logic memory_read_strobe_oe_o,
  output logic memory_write_strobe_n_o,
  output logic memory_write_strobe_oe_o,
  output logic rom_select_n_o,
  output logic ram_select_n_o,
  output logic sel_oe_o,
  output logic io_select_n_o,
  output logic io_select_oe_o,
  output logic wait_oe_o,
  output logic int0_oe_o
);
  import emu_pin_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] mode_s1;
    logic [1:0] mode;
    logic rst_s1;
    logic rst_s2;
    logic [STRETCH_W-1:0] stretch;
    logic int_rst;
    logic osc_en;
    logic uart_en;
    logic periph_en;
    logic div2;
    logic bus_oe;
    logic addr_oe;
    logic a18_oe;
    logic data_oe;
    logic rw_oe;
    logic emu_oe;
    logic mrd_n;
    logic mrd_oe;
    logic mwr_n;
    logic mwr_oe;
    logic rom_n;
    logic ram_n;
    logic sel_oe;
    logic ios_n;
    logic ios_oe;
    logic wait_oe;
    logic int0_oe;
  } state_t;

  state_t cur;
  state_t next_cur;

  localparam state_t STATE_RESET = '{
    mode_s1: MODE_RESET, mode: MODE_RESET, rst_s1: 1'b0, rst_s2: 1'b0,
    stretch: STRETCH_LOAD, int_rst: 1'b1, osc_en: 1'b0, uart_en: 1'b0,
    periph_en: 1'b0, div2: SER_DIV2_RESET, bus_oe: 1'b0, addr_oe: 1'b0,
    a18_oe: 1'b0, data_oe: 1'b0, rw_oe: 1'b0, emu_oe: 1'b0,
    mrd_n: 1'b1, mrd_oe: 1'b0, mwr_n: 1'b1, mwr_oe: 1'b0,
    rom_n: 1'b1, ram_n: 1'b1, sel_oe: 1'b0, ios_n: 1'b1, ios_oe: 1'b0,
    wait_oe: 1'b0, int0_oe: 1'b0
  };

  function automatic logic is_mode(input logic [1:0] m, input logic [1:0] want);
    is_mode = (m == want);
  endfunction

  logic normal;
  logic adapter;
  logic probe;
  logic pd;
  logic rst_req;

  always_comb begin
    normal = is_mode(cur.mode, MODE_NORMAL);
    adapter = is_mode(cur.mode, MODE_ADAPTER);
    probe = is_mode(cur.mode, MODE_PROBE);
    pd = cpu_power_down_i;
    next_cur = cur;
    // ==========================================================
    // Synchronisers: first stage is read only by the second
    next_cur.mode_s1 = {emu_select_high_i, emu_select_low_i}; // RQ1
    next_cur.mode = cur.mode_s1;
    next_cur.rst_s1 = ~reset_pin_n_i;
    next_cur.rst_s2 = cur.rst_s1;
    // ==========================================================
    // Reset: one-shot in normal mode, direct in adapter mode
    rst_req = cur.rst_s2;
    if (adapter) begin
      next_cur.int_rst = rst_req; // RQ7
      next_cur.stretch = '0;
    end else if (rst_req) begin
      next_cur.stretch = STRETCH_LOAD; // RQ7
      next_cur.int_rst = 1'b1;
    end else if (cur.stretch != '0) begin
      next_cur.stretch = cur.stretch - 1'b1;
      next_cur.int_rst = 1'b1;
    end else begin
      next_cur.int_rst = 1'b0;
    end
    // Divider select returns to undivided under internal reset
    if (cur.int_rst) begin
      next_cur.div2 = SER_DIV2_RESET; // RQ6 RQ16
    end else if (ser_div2_we_i) begin
      next_cur.div2 = ser_div2_req_i; // RQ17
    end
    // ==========================================================
    // Function enables
    next_cur.osc_en = normal; // RQ8
    next_cur.periph_en = (normal | adapter) & ~cur.int_rst; // RQ2 RQ6
    next_cur.uart_en = (normal | adapter) & ~cur.int_rst & ~pd; // RQ15
    // ==========================================================
    // CPU-side pins: the on-chip CPU drives them in normal mode only; wait and interrupt-0 drive in adapter mode
    next_cur.bus_oe = normal & cpu_bus_drive_i; // RQ3 RQ4
    next_cur.addr_oe = normal & cpu_bus_drive_i & ~pd; // RQ13
    next_cur.a18_oe = normal & (a18_is_addr_i ? (cpu_bus_drive_i & ~pd) : 1'b1); // RQ13 RQ9
    next_cur.data_oe = normal & cpu_bus_drive_i & ~pd; // RQ14
    next_cur.rw_oe = normal & cpu_bus_drive_i & ~pd; // RQ12
    next_cur.emu_oe = normal; // RQ3
    next_cur.wait_oe = adapter & wait_drive_i; // RQ3
    next_cur.int0_oe = adapter & int0_low_i; // RQ3
    // ==========================================================
    // Chip selects alive in normal and adapter modes; muxed strobes in normal mode only
    if (pd & normal) begin
      next_cur.mrd_n = 1'b1; // RQ10
      next_cur.mwr_n = 1'b1; // RQ10
    end else begin
      next_cur.mrd_n = memory_read_strobe_n_i;
      next_cur.mwr_n = memory_write_strobe_n_i;
    end
    next_cur.mrd_oe = normal & mrd_mux_sel_i; // RQ10
    next_cur.mwr_oe = normal & mwr_mux_sel_i; // RQ10
    next_cur.rom_n = pd ? 1'b1 : rom_select_n_i; // RQ11
    next_cur.ram_n = pd ? 1'b1 : ram_select_n_i; // RQ11
    next_cur.sel_oe = ~probe & ~is_mode(cur.mode, MODE_TEST) & ~cur.int_rst; // RQ2 RQ4
    next_cur.ios_n = io_select_n_i;
    next_cur.ios_oe = (normal | adapter) & io_mux_sel_i & ~pd & ~cur.int_rst; // RQ12 RQ2
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= STATE_RESET;
    end else if (clk_en_i) begin
      cur <= next_cur;
    end
  end

  assign mode_o = cur.mode;
  assign internal_reset_o = cur.int_rst;
  assign osc_enable_o = cur.osc_en;
  assign host_uart_enable_o = cur.uart_en;
  assign peripherals_enable_o = cur.periph_en;
  assign ser_div2_o = cur.div2;
  assign cpu_bus_oe_o = cur.bus_oe;
  assign addr_oe_o = cur.addr_oe;
  assign a18_oe_o = cur.a18_oe;
  assign data_oe_o = cur.data_oe;
  assign rw_strobe_oe_o = cur.rw_oe;
  assign emu_only_oe_o = cur.emu_oe;
  assign memory_read_strobe_n_o = cur.mrd_n;
  assign memory_read_strobe_oe_o = cur.mrd_oe;
  assign memory_write_strobe_n_o = cur.mwr_n;
  assign memory_write_strobe_oe_o = cur.mwr_oe;
  assign rom_select_n_o = cur.rom_n;
  assign ram_select_n_o = cur.ram_n;
  assign sel_oe_o = cur.sel_oe;
  assign io_select_n_o = cur.ios_n;
  assign io_select_oe_o = cur.ios_oe;
  assign wait_oe_o = cur.wait_oe;
  assign int0_oe_o = cur.int0_oe;

  // ==========================================================
  // Checks
  chk_probe_floats: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(mode_o) == MODE_PROBE |->
      !cpu_bus_oe_o && !data_oe_o && !sel_oe_o && !wait_oe_o && !int0_oe_o && !emu_only_oe_o)
    else $error("output driven in probe mode"); // RQ4
  chk_osc_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(mode_o) != MODE_NORMAL |-> !osc_enable_o)
    else $error("oscillator on in emulation mode"); // RQ8
  chk_adapter_inputs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(mode_o) == MODE_ADAPTER |-> !cpu_bus_oe_o && !addr_oe_o && !emu_only_oe_o)
    else $error("cpu pin driven in adapter mode"); // RQ3
  chk_selects_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(cpu_power_down_i) |-> rom_select_n_o && ram_select_n_o)
    else $error("chip select low in power-down"); // RQ11
  chk_data_float: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(cpu_power_down_i) |-> !data_oe_o && !addr_oe_o && !rw_strobe_oe_o)
    else $error("bus driven in power-down"); // RQ14
  chk_uart_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(cpu_power_down_i) |-> !host_uart_enable_o)
    else $error("host uart enabled in power-down"); // RQ15
  chk_strobe_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(cpu_power_down_i) && $past(mode_o) == MODE_NORMAL
      |-> memory_read_strobe_n_o && memory_write_strobe_n_o)
    else $error("memory strobe low in power-down"); // RQ10
  chk_iosel_float: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(cpu_power_down_i) |-> !io_select_oe_o)
    else $error("io select driven in power-down"); // RQ12
  chk_stretch_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && mode_o == MODE_NORMAL && $fell(cur.rst_s2) ##1 (clk_en_i && mode_o == MODE_NORMAL) [*8]
      |-> internal_reset_o)
    else $error("reset stretch too short"); // RQ7
  chk_div_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i && $past(clk_en_i) && $past(internal_reset_o) |-> !ser_div2_o)
    else $error("serial divider not undivided after reset"); // RQ16
endmodule

/* File: tb/emulator_model.sv */
// Far-side model: the emulator or adapter that straps the mode pins.
// Assumes the bench asks for a mode just after a rising clock edge.
module emulator_model
  import emu_pin_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [1:0] mode_req_i,
  output logic emu_select_low_o,
  output logic emu_select_high_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] strap;
  initial strap = MODE_NORMAL;
  // Test encoding is never strapped, the request is dropped
  always @(posedge sys_clk_i) begin
    if (mode_req_i != MODE_TEST) begin
      strap <= mode_req_i;
    end
  end
  assign emu_select_low_o = strap[0];
  assign emu_select_high_o = strap[1];
endmodule

/* File: tb/test_emulation_mode_pin_control.sv */
// Self-checking bench for the emulation-mode pin control block.
// Assumes the emulator model owns the mode pins; all else is driven here.
module test_emulation_mode_pin_control
  import emu_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_i, clk_en_i, emu_select_low_i, emu_select_high_i, reset_pin_n_i;
  logic cpu_power_down_i, mrd_mux_sel_i, mwr_mux_sel_i, io_mux_sel_i, a18_is_addr_i;
  logic ser_div2_req_i, ser_div2_we_i, cpu_bus_drive_i, memory_read_strobe_n_i, wait_drive_i;
  logic memory_write_strobe_n_i, rom_select_n_i, ram_select_n_i, io_select_n_i, int0_low_i;
  logic [1:0] mode_o, mode_req;
  logic internal_reset_o, osc_enable_o, host_uart_enable_o, peripherals_enable_o, ser_div2_o;
  logic cpu_bus_oe_o, addr_oe_o, a18_oe_o, data_oe_o, rw_strobe_oe_o, emu_only_oe_o, sel_oe_o;
  logic memory_read_strobe_n_o, memory_read_strobe_oe_o, memory_write_strobe_n_o, memory_write_strobe_oe_o;
  logic rom_select_n_o, ram_select_n_o, io_select_n_o, io_select_oe_o, wait_oe_o, int0_oe_o;
  int num_errors, comparisons, i;
  emulation_mode_pin_control i_emulation_mode_pin_control (
    .sys_clk_i, .rst_i, .clk_en_i, .emu_select_low_i, .emu_select_high_i, .reset_pin_n_i,
    .cpu_power_down_i, .mrd_mux_sel_i, .mwr_mux_sel_i, .io_mux_sel_i, .a18_is_addr_i,
    .ser_div2_req_i, .ser_div2_we_i, .cpu_bus_drive_i, .memory_read_strobe_n_i, .memory_write_strobe_n_i,
    .rom_select_n_i, .ram_select_n_i, .io_select_n_i, .wait_drive_i, .int0_low_i, .mode_o, .internal_reset_o,
    .osc_enable_o, .host_uart_enable_o, .peripherals_enable_o, .ser_div2_o, .cpu_bus_oe_o, .addr_oe_o,
    .a18_oe_o, .data_oe_o, .rw_strobe_oe_o, .emu_only_oe_o, .memory_read_strobe_n_o, .memory_read_strobe_oe_o,
    .memory_write_strobe_n_o, .memory_write_strobe_oe_o, .rom_select_n_o, .ram_select_n_o, .sel_oe_o,
    .io_select_n_o, .io_select_oe_o, .wait_oe_o, .int0_oe_o);
  emulator_model i_emulator_model (.sys_clk_i, .mode_req_i(mode_req),
    .emu_select_low_o(emu_select_low_i), .emu_select_high_o(emu_select_high_i));
  always #2 sys_clk_i = ~sys_clk_i;
  // ==========================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Sync plus register latency is 3 cycles; 6 leaves margin for the model
  task automatic set_mode(input logic [1:0] m);
    cyc(1);
    mode_req <= m;
    cyc(6);
    #1;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_modes;
    set_mode(MODE_NORMAL);
    chk(cpu_bus_oe_o, 1);
    chk(emu_only_oe_o, 1);
    chk(wait_oe_o, 0);
    chk(osc_enable_o, 1);
    set_mode(MODE_ADAPTER);
    chk(mode_o, MODE_ADAPTER);
    chk(cpu_bus_oe_o, 0);
    chk(addr_oe_o, 0);
    chk(a18_oe_o, 0);
    chk(emu_only_oe_o, 0);
    chk(wait_oe_o, 1);
    chk(int0_oe_o, 1);
    chk(osc_enable_o, 0);
    chk(peripherals_enable_o, 1);
    chk(sel_oe_o, 1);
    chk({io_select_oe_o, io_select_n_o}, 2'h2);
    set_mode(MODE_PROBE);
    chk(cpu_bus_oe_o, 0);
    chk(data_oe_o, 0);
    chk(sel_oe_o, 0);
    chk(int0_oe_o, 0);
    chk(osc_enable_o, 0);
    set_mode(MODE_TEST);
    chk(mode_o, MODE_PROBE);
    $display("test_modes done");
  endtask
  task automatic test_power_down;
    set_mode(MODE_NORMAL);
    cyc(1);
    cpu_power_down_i <= 1'b1;
    cyc(2);
    #1;
    chk({memory_read_strobe_n_o, memory_read_strobe_oe_o}, 2'h3);
    chk({memory_write_strobe_n_o, memory_write_strobe_oe_o}, 2'h3);
    chk({rom_select_n_o, ram_select_n_o}, 2'h3);
    chk({rw_strobe_oe_o, io_select_oe_o}, 2'h0);
    chk({addr_oe_o, a18_oe_o}, 2'h0);
    chk(data_oe_o, 0);
    chk(host_uart_enable_o, 0);
    cyc(1);
    a18_is_addr_i <= 1'b0;
    cpu_power_down_i <= 1'b0;
    cyc(2);
    #1;
    chk({rom_select_n_o, memory_read_strobe_n_o}, 2'h0);
    chk({a18_oe_o, host_uart_enable_o}, 2'h3);
    cyc(1);
    {memory_read_strobe_n_i, rom_select_n_i} <= 2'h3;
    cyc(2);
    #1;
    chk({rom_select_n_o, memory_read_strobe_n_o}, 2'h3);
    $display("test_power_down done");
  endtask
  task automatic test_reset;
    cyc(1);
    {ser_div2_req_i, ser_div2_we_i} <= 2'h3;
    // Emulator owns the shared pin as address bit 18 in adapter mode
    a18_is_addr_i <= 1'b1;
    cyc(1);
    ser_div2_we_i <= 1'b0;
    cyc(1);
    #1;
    chk(ser_div2_o, 1);
    cyc(1);
    reset_pin_n_i <= 1'b0;
    cyc(4);
    cyc(1);
    reset_pin_n_i <= 1'b1;
    cyc(14);
    #1;
    chk(internal_reset_o, 1);
    for (i = 0; i < 12 && internal_reset_o !== 1'b0; i++) begin
      cyc(1);
      #1;
    end
    if (internal_reset_o !== 1'b0) begin
      num_errors++;
      end_sim;
    end
    chk(ser_div2_o, 0);
    set_mode(MODE_ADAPTER);
    cyc(1);
    reset_pin_n_i <= 1'b0;
    cyc(4);
    #1;
    chk(internal_reset_o, 1);
    cyc(1);
    reset_pin_n_i <= 1'b1;
    cyc(4);
    #1;
    chk(internal_reset_o, 0);
    $display("test_reset done");
  endtask
  task automatic test_after_reset;
    cyc(30);
    #1;
    chk({internal_reset_o, ser_div2_o}, 2'h0);
    $display("test_after_reset done");
  endtask
  // Low enable must hold every output, even across a power-down request
  task automatic test_clock_enable;
    cyc(1);
    clk_en_i <= 1'b0;
    cpu_power_down_i <= 1'b1;
    cyc(3);
    #1;
    chk({data_oe_o, host_uart_enable_o}, 2'h3);
    cyc(1);
    clk_en_i <= 1'b1;
    cyc(2);
    #1;
    chk({data_oe_o, host_uart_enable_o}, 2'h0);
    cyc(1);
    cpu_power_down_i <= 1'b0;
    $display("test_clock_enable done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {sys_clk_i, cpu_power_down_i, ser_div2_req_i, ser_div2_we_i, memory_read_strobe_n_i} = '0;
    {memory_write_strobe_n_i, rom_select_n_i, ram_select_n_i, io_select_n_i, mode_req} = '0;
    {rst_i, clk_en_i, reset_pin_n_i, mrd_mux_sel_i, mwr_mux_sel_i, io_mux_sel_i} = '1;
    {a18_is_addr_i, cpu_bus_drive_i, wait_drive_i, int0_low_i} = '1;
    num_errors = 0;
    comparisons = 0;
    cyc(3);
    rst_i <= 1'b0;
    test_after_reset;
    test_clock_enable;
    test_modes;
    test_power_down;
    test_reset;
    end_sim;
  end
endmodule
